// *** hw/sampling_clock_and_clamp_control_pkg.sv ***
// Shared constants for the sampling clock and clamp control block.
// Assumes an 8-bit register port with byte-wide data and byte addresses.

package sampling_clock_and_clamp_control_pkg;

  // ----------------------------------------------------------------
  // Register port, phase field and counter widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PHASE_W = 5;
  localparam int unsigned COUNT_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC_CTRL_ADDR = 8'h0e;
  localparam logic [7:0] CLAMP_CTRL_ADDR = 8'h0f;
  localparam logic [7:0] CLOCK_SEL_ADDR = 8'h15;
  localparam logic [7:0] CLAMP_DELAY_ADDR = 8'h20;
  localparam logic [7:0] CLAMP_WIDTH_ADDR = 8'h21;
  localparam logic [7:0] STATUS_ADDR = 8'h22;
  localparam logic [7:0] MODE_ADDR = 8'h23;
  localparam logic [7:0] PHASE_ADDR = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned HS_POL_BIT = 6;
  localparam int unsigned EXT_CLAMP_BIT = 7;
  localparam int unsigned CLAMP_POL_BIT = 6;
  localparam int unsigned COAST_POL_BIT = 3;
  localparam int unsigned EXT_CLK_BIT = 0;
  localparam int unsigned YUV_BIT = 0;
  localparam int unsigned ST_CLAMP_BIT = 0;
  localparam int unsigned ST_COAST_BIT = 1;
  localparam int unsigned ST_HSYNC_BIT = 2;
  localparam int unsigned ST_GREEN_BIT = 3;
  localparam int unsigned ST_EXTCLK_BIT = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic HS_POL_RST = 1'b1;
  localparam logic EXT_CLAMP_RST = 1'b0;
  localparam logic CLAMP_POL_RST = 1'b1;
  localparam logic COAST_POL_RST = 1'b1;
  localparam logic EXT_CLK_RST = 1'b0;
  localparam logic YUV_RST = 1'b0;
  localparam logic [7:0] CLAMP_DELAY_RST = 8'h08;
  localparam logic [7:0] CLAMP_WIDTH_RST = 8'h14;
  localparam logic [4:0] PHASE_RST = 5'h00;

endpackage

// *** hw/clamp_timer.sv ***
// Internal clamp timer: delay then duration after each start pulse.
// Assumes one count per pixel clock cycle, which is core_clk here.

`timescale 1ns/10ps
`default_nettype none

module clamp_timer #(
  parameter int unsigned COUNT_W = sampling_clock_and_clamp_control_pkg::COUNT_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic startPulse,
  input wire logic [COUNT_W-1:0] delayCount,
  input wire logic [COUNT_W-1:0] widthCount,
  output logic clampOn
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    DELAY = 3'b010,
    HOLD = 3'b100
  } phase_t;

  typedef struct packed {
    phase_t state;
    logic [COUNT_W-1:0] cnt;
  } timer_t;

  timer_t s_q;
  timer_t s_d;

  if (COUNT_W < 1 || COUNT_W > 8) begin : g_bad_width
    $error("clamp_timer: COUNT_W must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    case (s_q.state)
      DELAY: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == 1) begin
          s_d.state = (widthCount == 0) ? IDLE : HOLD;
          s_d.cnt = widthCount;
        end
      end
      HOLD: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == 1) begin
          s_d.state = IDLE;
        end
      end
      default: begin
        s_d.state = IDLE;
      end
    endcase
    // A new edge restarts both counts, even mid-interval [R16]
    if (startPulse) begin
      if (delayCount != 0) begin
        s_d.state = DELAY;
        s_d.cnt = delayCount;
      end else begin
        s_d.state = (widthCount == 0) ? IDLE : HOLD;
        s_d.cnt = widthCount;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q.state <= IDLE;
      s_q.cnt <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clampOn = (s_q.state == HOLD); // [R2]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_restart;
    @(posedge core_clk) disable iff (sys_rst)
    startPulse && delayCount != 0 |=> s_q.state == DELAY && s_q.cnt == $past(delayCount);
  endproperty
  a_restart: assert property (p_restart) else $error("Timer did not restart delay"); // [R16]

  property p_hold_end;
    @(posedge core_clk) disable iff (sys_rst)
    s_q.state == HOLD && s_q.cnt == 1 && !startPulse |=> s_q.state == IDLE;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("Clamp interval overran"); // [R2]

endmodule

`default_nettype wire

// *** hw/sampling_clock_and_clamp_control.sv ***
// Control logic around the digitiser sampling path: clamp, coast,
// clock source, sampling inversion and green-channel sync output.
// Assumes all pins are synchronous to core_clk, the pixel clock.
//
// What this block and the controller around it do
// (R1) External clamp select picks clamp pin; resets 0
// (R2) Select 0: ignore pin, time clamp internally
// (R3) Clamp polarity bit sets clamp pin level
// (R4) Clamp to ground in RGB, midscale YUV
// (R5) Hold input freezes clock generator sync
// (R6) Hold polarity bit sets level; resets 1
// (R7) External clock select uses external clock pin
// (R8) Other functions, phase adjust, keep working
// (R9) Inversion input shifts sampling half a pixel
// (R10) Controller alternates odd and even pixel frames; the model just follows invReq, set once per run
// (R11) Controller toggles inversion only during blanking
// (R12) Drive comparator result out uninverted
// (R13) Unused clamp pin low, select 0
// (R14) Unused hold input kept inactive by polarity
// (R15) Leading edge for clock, trailing for clamp
// (R16) Clamp counters restart each trailing edge

`timescale 1ns/10ps
`default_nettype none

module sampling_clock_and_clamp_control #(
  parameter int unsigned COUNT_W = sampling_clock_and_clamp_control_pkg::COUNT_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic hsyncIn,
  input wire logic clampIn,
  input wire logic coastIn,
  input wire logic altClockInput,
  input wire logic samplePhaseInvert,
  input wire logic greenSyncCompare,
  output logic clampActive,
  output logic clampToGround,
  output logic clampToMidscale,
  output logic pllRefPulse,
  output logic coastActive,
  output logic altClockSelect,
  output logic altClockSeen,
  output logic sampleClockInvert,
  output logic [4:0] phaseAdjust,
  output logic greenSyncOut
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hsPrev;
    logic hsPol;
    logic extClamp;
    logic clampPol;
    logic coastPol;
    logic extClk;
    logic yuv;
    logic [COUNT_W-1:0] clampDelay;
    logic [COUNT_W-1:0] clampWidth;
    logic [4:0] phase;
    logic [7:0] rdData;
    logic clampActive;
    logic toGround;
    logic toMid;
    logic pllRef;
    logic coastActive;
    logic altSeen;
    logic invert;
    logic greenSync;
  } ctrl_t;

  ctrl_t s_q;
  ctrl_t s_d;
  logic timerClamp;
  logic riseEdge;
  logic fallEdge;
  logic leadEdge;
  logic trailEdge;
  logic coastNow;
  logic extClampNow;

  if (COUNT_W < 1 || COUNT_W > sampling_clock_and_clamp_control_pkg::DATA_W) begin : g_bad_width
    $error("COUNT_W must fit the 8-bit register data");
  end

  // Polarity bit 1 means the pin is active high
  function automatic logic pinActive(input logic pin, input logic pol);
    pinActive = (pin == pol);
  endfunction

  // ----------------------------------------------------------------
  // Sync edges and qualifiers
  // ----------------------------------------------------------------
  assign riseEdge = hsyncIn & ~s_q.hsPrev;
  assign fallEdge = ~hsyncIn & s_q.hsPrev;
  assign leadEdge = s_q.hsPol ? riseEdge : fallEdge; // [R15]
  assign trailEdge = s_q.hsPol ? fallEdge : riseEdge; // [R15]
  assign coastNow = pinActive(coastIn, s_q.coastPol); // [R6]
  assign extClampNow = pinActive(clampIn, s_q.clampPol); // [R3]

  clamp_timer #(
    .COUNT_W(COUNT_W)
  ) u_clamp_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .startPulse(trailEdge),
    .delayCount(s_q.clampDelay),
    .widthCount(s_q.clampWidth),
    .clampOn(timerClamp)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.hsPrev = hsyncIn;

    // Register writes; reserved bits are not stored
    if (regWrEn) begin
      if (regAddr == sampling_clock_and_clamp_control_pkg::SYNC_CTRL_ADDR) begin
        s_d.hsPol = regWrData[sampling_clock_and_clamp_control_pkg::HS_POL_BIT];
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::CLAMP_CTRL_ADDR) begin
        s_d.extClamp = regWrData[sampling_clock_and_clamp_control_pkg::EXT_CLAMP_BIT]; // [R1]
        s_d.clampPol = regWrData[sampling_clock_and_clamp_control_pkg::CLAMP_POL_BIT]; // [R3]
        s_d.coastPol = regWrData[sampling_clock_and_clamp_control_pkg::COAST_POL_BIT]; // [R6]
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::CLOCK_SEL_ADDR) begin
        s_d.extClk = regWrData[sampling_clock_and_clamp_control_pkg::EXT_CLK_BIT]; // [R7]
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::CLAMP_DELAY_ADDR) begin
        s_d.clampDelay = regWrData[COUNT_W-1:0];
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::CLAMP_WIDTH_ADDR) begin
        s_d.clampWidth = regWrData[COUNT_W-1:0];
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::MODE_ADDR) begin
        s_d.yuv = regWrData[sampling_clock_and_clamp_control_pkg::YUV_BIT];
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::PHASE_ADDR) begin
        s_d.phase = regWrData[4:0];
      end
    end

    // Register reads; unmapped offsets and reserved bits read zero
    s_d.rdData = '0;
    if (regRdEn) begin
      if (regAddr == sampling_clock_and_clamp_control_pkg::SYNC_CTRL_ADDR) begin
        s_d.rdData[sampling_clock_and_clamp_control_pkg::HS_POL_BIT] = s_q.hsPol;
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::CLAMP_CTRL_ADDR) begin
        s_d.rdData[sampling_clock_and_clamp_control_pkg::EXT_CLAMP_BIT] = s_q.extClamp;
        s_d.rdData[sampling_clock_and_clamp_control_pkg::CLAMP_POL_BIT] = s_q.clampPol;
        s_d.rdData[sampling_clock_and_clamp_control_pkg::COAST_POL_BIT] = s_q.coastPol;
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::CLOCK_SEL_ADDR) begin
        s_d.rdData[sampling_clock_and_clamp_control_pkg::EXT_CLK_BIT] = s_q.extClk;
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::CLAMP_DELAY_ADDR) begin
        s_d.rdData[COUNT_W-1:0] = s_q.clampDelay;
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::CLAMP_WIDTH_ADDR) begin
        s_d.rdData[COUNT_W-1:0] = s_q.clampWidth;
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::STATUS_ADDR) begin
        s_d.rdData[sampling_clock_and_clamp_control_pkg::ST_CLAMP_BIT] = s_q.clampActive;
        s_d.rdData[sampling_clock_and_clamp_control_pkg::ST_COAST_BIT] = s_q.coastActive;
        s_d.rdData[sampling_clock_and_clamp_control_pkg::ST_HSYNC_BIT] = s_q.hsPrev;
        s_d.rdData[sampling_clock_and_clamp_control_pkg::ST_GREEN_BIT] = s_q.greenSync;
        s_d.rdData[sampling_clock_and_clamp_control_pkg::ST_EXTCLK_BIT] = s_q.altSeen;
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::MODE_ADDR) begin
        s_d.rdData[sampling_clock_and_clamp_control_pkg::YUV_BIT] = s_q.yuv;
      end else if (regAddr == sampling_clock_and_clamp_control_pkg::PHASE_ADDR) begin
        s_d.rdData[4:0] = s_q.phase;
      end
    end

    // Clamp source: the pin is ignored unless selected
    s_d.clampActive = s_q.extClamp ? extClampNow : timerClamp; // [R1] [R2]
    s_d.toGround = s_d.clampActive & ~s_q.yuv; // [R4]
    s_d.toMid = s_d.clampActive & s_q.yuv; // [R4]

    // Coast freezes the generator: no reference edge reaches it
    s_d.coastActive = coastNow; // [R5]
    s_d.pllRef = leadEdge & ~coastNow; // [R5] [R15]

    // External clock pin level while selected, only a presence hint for software
    s_d.altSeen = s_q.extClk & altClockInput; // [R7]

    // Inversion follows the pin; glitch-free use is the controller's job
    s_d.invert = samplePhaseInvert; // [R9] [R11]
    s_d.greenSync = greenSyncCompare; // [R12]
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.hsPol <= sampling_clock_and_clamp_control_pkg::HS_POL_RST;
      s_q.extClamp <= sampling_clock_and_clamp_control_pkg::EXT_CLAMP_RST; // [R1]
      s_q.clampPol <= sampling_clock_and_clamp_control_pkg::CLAMP_POL_RST;
      s_q.coastPol <= sampling_clock_and_clamp_control_pkg::COAST_POL_RST; // [R6]
      s_q.extClk <= sampling_clock_and_clamp_control_pkg::EXT_CLK_RST;
      s_q.yuv <= sampling_clock_and_clamp_control_pkg::YUV_RST;
      s_q.clampDelay <= sampling_clock_and_clamp_control_pkg::CLAMP_DELAY_RST[COUNT_W-1:0];
      s_q.clampWidth <= sampling_clock_and_clamp_control_pkg::CLAMP_WIDTH_RST[COUNT_W-1:0];
      s_q.phase <= sampling_clock_and_clamp_control_pkg::PHASE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state record
  // ----------------------------------------------------------------
  assign regRdData = s_q.rdData;
  assign clampActive = s_q.clampActive;
  assign clampToGround = s_q.toGround;
  assign clampToMidscale = s_q.toMid;
  assign pllRefPulse = s_q.pllRef;
  assign coastActive = s_q.coastActive;
  assign altClockSelect = s_q.extClk; // [R7]
  assign altClockSeen = s_q.altSeen;
  assign sampleClockInvert = s_q.invert;
  // Phase setting is independent of the clock source [R8]
  assign phaseAdjust = s_q.phase;
  assign greenSyncOut = s_q.greenSync;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ext_clamp_on;
    @(posedge core_clk) disable iff (sys_rst)
    s_q.extClamp && clampIn == s_q.clampPol |=> clampActive;
  endproperty
  a_ext_clamp_on: assert property (p_ext_clamp_on) else $error("Selected clamp pin not followed"); // [R1]

  property p_pin_ignored;
    @(posedge core_clk) disable iff (sys_rst)
    !s_q.extClamp |=> clampActive == $past(timerClamp);
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("Clamp pin used while deselected"); // [R2]

  property p_clamp_pol;
    @(posedge core_clk) disable iff (sys_rst)
    s_q.extClamp && clampIn != s_q.clampPol |=> !clampActive;
  endproperty
  a_clamp_pol: assert property (p_clamp_pol) else $error("Inactive clamp level gave a clamp"); // [R3]

  property p_clamp_level;
    @(posedge core_clk) disable iff (sys_rst)
    clampActive |-> (clampToGround != clampToMidscale) && (clampToMidscale == $past(s_q.yuv));
  endproperty
  a_clamp_level: assert property (p_clamp_level) else $error("Wrong clamp reference level"); // [R4]

  property p_coast_block;
    @(posedge core_clk) disable iff (sys_rst)
    coastIn == s_q.coastPol |=> coastActive && !pllRefPulse;
  endproperty
  a_coast_block: assert property (p_coast_block) else $error("Reference edge passed during coast"); // [R5]

  property p_coast_cause;
    @(posedge core_clk) disable iff (sys_rst)
    $rose(coastActive) |-> $past(coastIn) == $past(s_q.coastPol);
  endproperty
  a_coast_cause: assert property (p_coast_cause) else $error("Coast without active hold input"); // [R6]

  property p_clock_select;
    @(posedge core_clk) disable iff (sys_rst)
    regWrEn && regAddr == sampling_clock_and_clamp_control_pkg::CLOCK_SEL_ADDR
      |=> altClockSelect == $past(regWrData[0]);
  endproperty
  a_clock_select: assert property (p_clock_select) else $error("Clock select write lost"); // [R7]

  property p_phase_kept;
    @(posedge core_clk) disable iff (sys_rst)
    !(regWrEn && regAddr == sampling_clock_and_clamp_control_pkg::PHASE_ADDR) |=> $stable(phaseAdjust);
  endproperty
  a_phase_kept: assert property (p_phase_kept) else $error("Phase changed without a write"); // [R8]

  property p_invert;
    @(posedge core_clk) disable iff (sys_rst)
    samplePhaseInvert |=> sampleClockInvert;
  endproperty
  a_invert: assert property (p_invert) else $error("Sampling inversion not applied"); // [R9]

  property p_invert_off;
    @(posedge core_clk) disable iff (sys_rst)
    !samplePhaseInvert |=> !sampleClockInvert;
  endproperty
  a_invert_off: assert property (p_invert_off) else $error("Sampling inversion stuck on"); // [R9]

  property p_coast_release;
    @(posedge core_clk) disable iff (sys_rst)
    coastIn != s_q.coastPol |=> !coastActive;
  endproperty
  a_coast_release: assert property (p_coast_release) else $error("Coast held with inactive hold input"); // [R6]

  property p_green;
    @(posedge core_clk) disable iff (sys_rst)
    ##1 greenSyncOut == $past(greenSyncCompare);
  endproperty
  a_green: assert property (p_green) else $error("Green sync output inverted or late"); // [R12]

  property p_lead_edge;
    @(posedge core_clk) disable iff (sys_rst)
    pllRefPulse |-> $past(hsyncIn) == $past(s_q.hsPol) && $past(s_q.hsPrev) != $past(s_q.hsPol);
  endproperty
  a_lead_edge: assert property (p_lead_edge) else $error("Reference pulse on wrong sync edge"); // [R15]

endmodule

`default_nettype wire

// *** tb/video_source_model.sv ***
// Far-side model: video source and system controller on the control pins.
// Assumes the bench supplies a random byte each cycle and the pin settings.
`timescale 1ns/10ps
`default_nettype none
module video_source_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [7:0] rnd,
  input wire logic [7:0] lineLen,
  input wire logic syncPol,
  input wire logic clampUse,
  input wire logic clampPol,
  input wire logic coastUse,
  input wire logic coastPol,
  input wire logic invReq,
  output logic hsyncIn,
  output logic clampIn,
  output logic coastIn,
  output logic altClockInput,
  output logic samplePhaseInvert,
  output logic greenSyncCompare
);
  // ----------------------------------------------------------------
  // Line timing, sync width 6, back porch clamp window 8..11
  // ----------------------------------------------------------------
  logic [7:0] pos;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos <= 8'h00;
      hsyncIn <= 1'b0;
      clampIn <= 1'b0;
      coastIn <= !coastPol;
      altClockInput <= 1'b0;
      samplePhaseInvert <= 1'b0;
      greenSyncCompare <= 1'b0;
    end else begin
      if (run) begin
        pos <= (pos + 8'h01 >= lineLen) ? 8'h00 : pos + 8'h01;
        hsyncIn <= (pos < 8'h06) == syncPol;
      end
      // Unused clamp pin held low, unused hold pin parked inactive
      clampIn <= clampUse && ((pos >= 8'h08 && pos < 8'h0c) == clampPol);
      coastIn <= coastUse ? rnd[0] : !coastPol;
      altClockInput <= rnd[1];
      greenSyncCompare <= rnd[2];
      // Phase flips only in the line's blanking tail, so odd/even frames stay clean
      if (run && pos + 8'h04 >= lineLen) begin
        samplePhaseInvert <= invReq;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/sampling_clock_and_clamp_control_tb_top.sv ***
// Self-checking bench for the sampling clock and clamp control block.
// Assumes video_source_model drives the pins and a 200 MHz core_clk.
`timescale 1ns/10ps
`default_nettype none
module sampling_clock_and_clamp_control_tb_top;
  logic core_clk, sys_rst, regWrEn, regRdEn, run, syncPol, clampUse, clampPol, coastUse, coastPol, invReq;
  logic [7:0] regAddr, regWrData, regRdData, rndState, lineLen;
  logic hsyncIn, clampIn, coastIn, altClockInput, samplePhaseInvert, greenSyncCompare;
  logic clampActive, clampToGround, clampToMidscale, pllRefPulse, coastActive;
  logic altClockSelect, altClockSeen, sampleClockInvert, greenSyncOut;
  logic [4:0] phaseAdjust, ePhase;
  logic [7:0] sh0e, sh0f, sh15, dly, wid, sh23, lD, lW, stat;
  logic hsPrev, lead, coastNow, eClamp, eGnd, eMid, ePll, eCoast, eSel, eSeen, eInv, eGreen;
  int errTotal, samplesChecked, cycles, since;
  localparam logic [7:0] ADR [9] = '{8'h0e, 8'h0f, 8'h15, 8'h20, 8'h21, 8'h23, 8'h24, 8'h30, 8'h22};
  localparam logic [7:0] RSTV [9] = '{8'h40, 8'h48, 8'h00, 8'h08, 8'h14, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MASK [8] = '{8'h40, 8'hc8, 8'h01, 8'hff, 8'hff, 8'h01, 8'h1f, 8'h00};
  // Corner rows: walk case, zero delay, zero width, restart mid-interval, long counts
  localparam logic [7:0] CD [5] = '{8'h02, 8'h00, 8'h05, 8'h02, 8'h0f};
  localparam logic [7:0] CW [5] = '{8'h03, 8'h01, 8'h00, 8'h3c, 8'h3f};
  localparam logic [7:0] CL [5] = '{8'h28, 8'h14, 8'h14, 8'h1e, 8'h60};

  sampling_clock_and_clamp_control dut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .hsyncIn(hsyncIn),
    .clampIn(clampIn), .coastIn(coastIn), .altClockInput(altClockInput), .samplePhaseInvert(samplePhaseInvert),
    .greenSyncCompare(greenSyncCompare), .clampActive(clampActive), .clampToGround(clampToGround),
    .clampToMidscale(clampToMidscale), .pllRefPulse(pllRefPulse), .coastActive(coastActive),
    .altClockSelect(altClockSelect), .altClockSeen(altClockSeen), .sampleClockInvert(sampleClockInvert),
    .phaseAdjust(phaseAdjust), .greenSyncOut(greenSyncOut));
  video_source_model src (.core_clk(core_clk), .sys_rst(sys_rst), .run(run), .rnd(rndState), .lineLen(lineLen),
    .syncPol(syncPol), .clampUse(clampUse), .clampPol(clampPol), .coastUse(coastUse), .coastPol(coastPol),
    .invReq(invReq), .hsyncIn(hsyncIn), .clampIn(clampIn), .coastIn(coastIn), .altClockInput(altClockInput),
    .samplePhaseInvert(samplePhaseInvert), .greenSyncCompare(greenSyncCompare));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic endOfTest;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask

  // ----------------------------------------------------------------
  // Reference: registered outputs worked out from the pins seen at each edge
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    rndState <= sys_rst ? 8'h5b : lfsr(rndState);
    if (sys_rst) begin
      {sh0e, sh0f, sh15, dly, wid, sh23} = {8'h40, 8'h48, 8'h00, 8'h08, 8'h14, 8'h00};
      {hsPrev, eClamp, eGnd, eMid, ePll, eCoast, eSel, eSeen, eInv, eGreen} = '0;
      ePhase = 5'h00;
      since = 1000;
      {lD, lW} = 16'h0000;
    end else begin
      // Status read returns the flags as they stood before this edge
      if (regRdEn && regAddr == 8'h22) begin
        stat = {3'h0, eSeen, eGreen, hsPrev, eCoast, eClamp};
      end
      lead = hsyncIn != hsPrev && hsyncIn == sh0e[6];
      coastNow = coastIn == sh0f[3];
      // A restarting edge still shows the old interval for one more cycle
      if (since < 1000) begin
        since++;
      end
      eClamp = sh0f[7] ? (clampIn == sh0f[6]) : (since >= lD + 1 && since <= lD + lW);
      if (hsyncIn != hsPrev && !lead) begin
        since = 0;
        lD = dly;
        lW = wid;
      end
      eGnd = eClamp && !sh23[0];
      eMid = eClamp && sh23[0];
      ePll = lead && !coastNow;
      eCoast = coastNow;
      eSeen = sh15[0] && altClockInput;
      eInv = samplePhaseInvert;
      eGreen = greenSyncCompare;
      hsPrev = hsyncIn;
      if (regWrEn) begin
        case (regAddr)
          8'h0e: sh0e = regWrData & 8'h40;
          8'h0f: sh0f = regWrData & 8'hc8;
          8'h15: sh15 = regWrData & 8'h01;
          8'h20: dly = regWrData;
          8'h21: wid = regWrData;
          8'h23: sh23 = regWrData & 8'h01;
          8'h24: ePhase = regWrData[4:0];
          default: ;
        endcase
      end
      // The select output is the register bit itself, so it follows a write at once
      eSel = sh15[0];
    end
  end

  always @(negedge core_clk) begin
    if (!sys_rst && cycles > 12) begin
      chk({7'h00, clampActive}, {7'h00, eClamp});
      chk({7'h00, clampToGround}, {7'h00, eGnd});
      chk({7'h00, clampToMidscale}, {7'h00, eMid});
      chk({7'h00, pllRefPulse}, {7'h00, ePll});
      chk({7'h00, coastActive}, {7'h00, eCoast});
      chk({7'h00, altClockSelect}, {7'h00, eSel});
      chk({7'h00, altClockSeen}, {7'h00, eSeen});
      chk({3'h0, phaseAdjust}, {3'h0, ePhase});
      chk({7'h00, sampleClockInvert}, {7'h00, eInv});
      chk({7'h00, greenSyncOut}, {7'h00, eGreen});
    end
  end

  // Ceiling is about three times the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      endOfTest();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] f, v;
    {regWrEn, regRdEn, run, clampUse, clampPol, coastUse, invReq} = '0;
    {syncPol, coastPol} = 2'b11;
    {regAddr, regWrData, lineLen} = {8'h00, 8'h00, 8'h28};
    sys_rst = 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(ADR[i], v);
      chk(v, i == 8 ? stat : RSTV[i]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(ADR[i], 8'hff);
      rd(ADR[i], v);
      chk(v, MASK[i]);
    end
    for (int i = 0; i < 14; i++) begin
      run <= 1'b0;
      repeat (80) @(posedge core_clk);
      f = rndState;
      syncPol <= f[0];
      clampUse <= i >= 5 && f[1];
      clampPol <= f[2];
      coastUse <= f[3];
      coastPol <= f[4];
      invReq <= f[5];
      wr(8'h0e, {1'b0, f[0], 6'h00});
      wr(8'h0f, {i >= 5 && f[1], f[2], 2'b00, f[4], 3'b000});
      wr(8'h15, {7'h00, f[6]});
      wr(8'h23, {7'h00, f[7]});
      wr(8'h24, rndState & 8'h1f);
      wr(8'h20, i < 5 ? CD[i] : rndState & 8'h0f);
      wr(8'h21, i < 5 ? CW[i] : rndState & 8'h3f);
      lineLen <= i < 5 ? CL[i] : 8'h28;
      run <= 1'b1;
      repeat (400) @(posedge core_clk);
    end
    endOfTest();
  end
endmodule
`default_nettype wire
